// ==== core/cec_rx_timing_checker.sv ====
// Receive timing checker for a single-wire CEC line, with an AXI4-Lite
// register slave and one level interrupt.
// Assumes CEC_IN is the raw line level from the pin, idle high.
`timescale 1ns/1ps

// Behaviour
// RULE1: Bits 14..12 code n gives longest start period 154+n sample periods.
// RULE2: Bits 10..8 code n gives shortest start period 141-n sample periods.
// RULE3: Bits 6..4 code n gives latest start rise at 128+n periods.
// RULE4: Bits 2..0 code n gives earliest start rise at 115-n periods.
// RULE5: Start bit accepted only when period and rise both lie in windows.
// RULE6: Waveform bits 22..20 give latest zero-bit rise, 56+n periods.
// RULE7: Waveform bits 18..16 give earliest zero-bit rise, 43-n periods.
// RULE8: Waveform bits 14..12 give latest one-bit rise, 26+n periods.
// RULE9: Waveform bits 10..8 give earliest one-bit rise, 13-n periods.
// RULE10: Waveform bit 0 enables detection and its error interrupt.
// RULE11: Enabled, each data bit is judged on all four; disabled, none.
// RULE12: Software stops reception and confirms before changing any timing.
// RULE13: Error when no rise by the latest zero-bit threshold.
// RULE14: Error when rise lands between latest one and earliest zero.
// RULE15: Error when rise comes before the earliest one-bit threshold.
// RULE16: Thresholds count sample periods from the falling edge, taken at rise.
module cec_rx_timing_checker
  import cec_rx_timing_pkg::*;
#(
  parameter int SAMPLE_DIV = SAMPLE_DIV_CYCLES
) (
  input  wire logic        MCLK,
  input  wire logic        NRST,
  input  wire logic        CEC_IN,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic             IRQ
);

  // Divider counter is 16 bits wide
  if (SAMPLE_DIV < 2 || SAMPLE_DIV > 65535) begin : g_bad_div
    $error("SAMPLE_DIV out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb, input logic [31:0] wmask);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return (r & wmask) | (old_v & ~wmask);
  endfunction

  function automatic logic [7:0] limit(input logic [7:0] base, input logic [2:0] code,
                                       input logic plus);
    return plus ? base + {5'd0, code} : base - {5'd0, code};
  endfunction

  function automatic logic known(input logic [7:0] addr);
    return addr == OFS_START_TIMING || addr == OFS_WAVE_CHECK || addr == OFS_IRQ_STATUS
        || addr == OFS_IRQ_MASK || addr == OFS_RX_CONTROL;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register slave

  logic        aw_got_q, aw_got_d;
  logic        w_got_q, w_got_d;
  logic [7:0]  awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0]  wstrb_q, wstrb_d;
  logic        bvalid_q, bvalid_d;
  logic [1:0]  bresp_q, bresp_d;
  logic        rvalid_q, rvalid_d;
  logic [1:0]  rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] start_timing_q, start_timing_d;
  logic [31:0] wave_check_q, wave_check_d;
  logic [31:0] irq_mask_q, irq_mask_d;
  logic [31:0] irq_status_q, irq_status_d;
  logic        rx_enable_q, rx_enable_d;
  logic [31:0] status_clr;
  logic [31:0] rx_ctl_w;
  logic        do_write;
  rx_events_type ev;

  assign S_AXI_AWREADY = !aw_got_q && !bvalid_q;
  assign S_AXI_WREADY  = !w_got_q && !bvalid_q;
  assign S_AXI_ARREADY = !rvalid_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RRESP   = rresp_q;
  assign S_AXI_RDATA   = rdata_q;
  assign IRQ           = |(irq_status_q & irq_mask_q);

  always_comb begin
    aw_got_d       = aw_got_q;
    w_got_d        = w_got_q;
    awaddr_d       = awaddr_q;
    wdata_d        = wdata_q;
    wstrb_d        = wstrb_q;
    bvalid_d       = bvalid_q;
    bresp_d        = bresp_q;
    start_timing_d = start_timing_q;
    wave_check_d   = wave_check_q;
    irq_mask_d     = irq_mask_q;
    rx_enable_d    = rx_enable_q;
    status_clr     = 32'h0000_0000;
    rx_ctl_w       = merge({31'd0, rx_enable_q}, wdata_q, wstrb_q, WMASK_RX_CONTROL);
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_got_d = 1'b1;
      awaddr_d = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_got_d = 1'b1;
      wdata_d = S_AXI_WDATA;
      wstrb_d = S_AXI_WSTRB;
    end
    do_write = aw_got_q && w_got_q;
    if (do_write) begin
      aw_got_d = 1'b0;
      w_got_d  = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = known(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      unique case (awaddr_q)
        OFS_START_TIMING: begin
          start_timing_d = merge(start_timing_q, wdata_q, wstrb_q,
                                 WMASK_START_TIMING); // [RULE1] [RULE2] [RULE3] [RULE4]
        end
        OFS_WAVE_CHECK: begin
          wave_check_d = merge(wave_check_q, wdata_q, wstrb_q,
                               WMASK_WAVE_CHECK); // [RULE6] [RULE7] [RULE8] [RULE9] [RULE10]
        end
        OFS_IRQ_STATUS: begin
          status_clr = merge(32'h0000_0000, wdata_q, wstrb_q, WMASK_IRQ);
        end
        OFS_IRQ_MASK: begin
          irq_mask_d = merge(irq_mask_q, wdata_q, wstrb_q, WMASK_IRQ);
        end
        OFS_RX_CONTROL: begin
          // Read back shows the receiver really idle once cleared [RULE12]
          rx_enable_d = rx_ctl_w[POS_RX_ENABLE];
        end
        default: begin
        end
      endcase
    end
    if (bvalid_q && S_AXI_BREADY) begin
      bvalid_d = 1'b0;
    end
  end

  // Event wins over a clear in the same cycle
  always_comb begin
    irq_status_d = (irq_status_q & ~status_clr) | {29'd0, ev};
  end

  always_comb begin
    rvalid_d = rvalid_q;
    rresp_d  = rresp_q;
    rdata_d  = rdata_q;
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_d = 1'b1;
      rresp_d  = known(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
      unique case (S_AXI_ARADDR)
        OFS_START_TIMING: rdata_d = start_timing_q;
        OFS_WAVE_CHECK:   rdata_d = wave_check_q;
        OFS_IRQ_STATUS:   rdata_d = irq_status_q;
        OFS_IRQ_MASK:     rdata_d = irq_mask_q;
        OFS_RX_CONTROL:   rdata_d = {31'd0, rx_enable_q};
        default:          rdata_d = 32'h0000_0000;
      endcase
    end else if (rvalid_q && S_AXI_RREADY) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      aw_got_q       <= 1'b0;
      w_got_q        <= 1'b0;
      awaddr_q       <= 8'h00;
      wdata_q        <= 32'h0000_0000;
      wstrb_q        <= 4'h0;
      bvalid_q       <= 1'b0;
      bresp_q        <= RESP_OKAY;
      rvalid_q       <= 1'b0;
      rresp_q        <= RESP_OKAY;
      rdata_q        <= 32'h0000_0000;
      start_timing_q <= RST_START_TIMING;
      wave_check_q   <= RST_WAVE_CHECK;
      irq_mask_q     <= RST_IRQ_MASK;
      irq_status_q   <= 32'h0000_0000;
      rx_enable_q    <= 1'b0;
    end else begin
      aw_got_q       <= aw_got_d;
      w_got_q        <= w_got_d;
      awaddr_q       <= awaddr_d;
      wdata_q        <= wdata_d;
      wstrb_q        <= wstrb_d;
      bvalid_q       <= bvalid_d;
      bresp_q        <= bresp_d;
      rvalid_q       <= rvalid_d;
      rresp_q        <= rresp_d;
      rdata_q        <= rdata_d;
      start_timing_q <= start_timing_d;
      wave_check_q   <= wave_check_d;
      irq_mask_q     <= irq_mask_d;
      irq_status_q   <= irq_status_d;
      rx_enable_q    <= rx_enable_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Thresholds from the codes

  rx_limits_type lim;
  logic          check_en;

  always_comb begin
    lim.start_period_max    = limit(BASE_START_PERIOD_MAX,
                                    start_timing_q[POS_START_PERIOD_MAX +: 3], 1'b1); // [RULE1]
    lim.start_period_min    = limit(BASE_START_PERIOD_MIN,
                                    start_timing_q[POS_START_PERIOD_MIN +: 3], 1'b0); // [RULE2]
    lim.start_rise_latest   = limit(BASE_START_RISE_LATEST,
                                    start_timing_q[POS_START_RISE_LATEST +: 3], 1'b1); // [RULE3]
    lim.start_rise_earliest = limit(BASE_START_RISE_EARLIEST,
                                    start_timing_q[POS_START_RISE_EARLIEST +: 3], 1'b0); // [RULE4]
    lim.zero_rise_latest    = limit(BASE_ZERO_RISE_LATEST,
                                    wave_check_q[POS_ZERO_RISE_LATEST +: 3], 1'b1); // [RULE6]
    lim.zero_rise_earliest  = limit(BASE_ZERO_RISE_EARLIEST,
                                    wave_check_q[POS_ZERO_RISE_EARLIEST +: 3], 1'b0); // [RULE7]
    lim.one_rise_latest     = limit(BASE_ONE_RISE_LATEST,
                                    wave_check_q[POS_ONE_RISE_LATEST +: 3], 1'b1); // [RULE8]
    lim.one_rise_earliest   = limit(BASE_ONE_RISE_EARLIEST,
                                    wave_check_q[POS_ONE_RISE_EARLIEST +: 3], 1'b0); // [RULE9]
    check_en = wave_check_q[POS_WAVE_CHECK_ENABLE]; // [RULE10]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line synchroniser and sampling tick

  logic [2:0]  sync_q, sync_d;
  logic        line_q, line_d;
  logic [15:0] div_q, div_d;
  logic        tick;
  logic        fall, rise;

  always_comb begin
    sync_d = {sync_q[1:0], CEC_IN};
    // Level moves only when second and third stages agree
    line_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : line_q;
    fall   = line_q && !line_d;
    rise   = !line_q && line_d;
    tick   = (div_q == 16'(SAMPLE_DIV - 1));
    div_d  = tick ? 16'h0000 : div_q + 16'h0001;
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      sync_q <= 3'b111;
      line_q <= 1'b1;
      div_q  <= 16'h0000;
    end else begin
      sync_q <= sync_d;
      line_q <= line_d;
      div_q  <= div_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit timing

  rx_state_type state_q, state_d;
  logic [7:0]   cnt_q, cnt_d;
  logic [7:0]   rise_at_q, rise_at_d;
  logic         start_fit;

  always_comb begin
    state_d   = state_q;
    rise_at_d = rise_at_q;
    ev        = '0;
    // Saturating count of sample periods since the last falling edge
    cnt_d     = (tick && cnt_q != 8'hFF) ? cnt_q + 8'h01 : cnt_q; // [RULE16]
    start_fit = cnt_q >= lim.start_period_min && cnt_q <= lim.start_period_max
             && rise_at_q >= lim.start_rise_earliest
             && rise_at_q <= lim.start_rise_latest; // [RULE5]
    unique case (state_q)
      ST_IDLE: begin
        if (fall) begin
          state_d = ST_START;
          cnt_d   = 8'h00; // [RULE16]
        end
      end
      ST_START: begin
        if (rise) begin
          rise_at_d = cnt_q; // [RULE16]
        end
        if (fall) begin
          cnt_d = 8'h00;
          if (start_fit) begin
            ev.start_ok = 1'b1; // [RULE5]
            state_d     = ST_BIT_LOW;
          end else begin
            // A rejected candidate may itself begin a new start bit
            ev.start_err = 1'b1; // [RULE5]
          end
        end else if (cnt_q > lim.start_period_max) begin
          ev.start_err = 1'b1; // [RULE5]
          state_d      = ST_IDLE;
        end
      end
      ST_BIT_LOW: begin
        if (rise) begin
          state_d = ST_BIT_HIGH;
          if (check_en) begin // [RULE11]
            if (cnt_q < lim.one_rise_earliest) begin
              ev.wave_err = 1'b1; // [RULE15]
            end
            if (cnt_q > lim.one_rise_latest && cnt_q < lim.zero_rise_earliest) begin
              ev.wave_err = 1'b1; // [RULE14]
            end
          end
        end else if (check_en && cnt_q > lim.zero_rise_latest) begin // [RULE11]
          ev.wave_err = 1'b1; // [RULE13]
          state_d     = ST_IDLE;
        end
      end
      ST_BIT_HIGH: begin
        if (fall) begin
          state_d = ST_BIT_LOW;
          cnt_d   = 8'h00; // [RULE16]
        end else if (cnt_q > lim.start_period_max) begin
          // Line idle longer than any bit: frame over
          state_d = ST_IDLE;
        end
      end
    endcase
    if (!rx_enable_q) begin
      state_d = ST_IDLE;
      ev      = '0;
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      state_q   <= ST_IDLE;
      cnt_q     <= 8'h00;
      rise_at_q <= 8'h00;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      rise_at_q <= rise_at_d;
    end
  end

endmodule

// ==== core/cec_rx_timing_pkg.sv ====
// Package for the receive timing checker: register map, field layout,
// threshold bases, counts and types. Assumes a 250 MHz system clock.
package cec_rx_timing_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFS_START_TIMING = 8'h00;
  localparam logic [7:0] OFS_WAVE_CHECK   = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS   = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK     = 8'h0C;
  localparam logic [7:0] OFS_RX_CONTROL   = 8'h10;

  // Reset values
  localparam logic [31:0] RST_START_TIMING = 32'h0000_0000;
  localparam logic [31:0] RST_WAVE_CHECK   = 32'h0000_0000;
  localparam logic [31:0] RST_IRQ_MASK     = 32'h0000_0000;

  // Writable bits of each register
  localparam logic [31:0] WMASK_START_TIMING = 32'h0000_7777;
  localparam logic [31:0] WMASK_WAVE_CHECK   = 32'h0077_7701;
  localparam logic [31:0] WMASK_IRQ          = 32'h0000_0007;
  localparam logic [31:0] WMASK_RX_CONTROL   = 32'h0000_0001;

  // Field positions (low bit of each 3-bit code; the two enables are single bits)
  localparam int POS_START_PERIOD_MAX    = 12;
  localparam int POS_START_PERIOD_MIN    = 8;
  localparam int POS_START_RISE_LATEST   = 4;
  localparam int POS_START_RISE_EARLIEST = 0;
  localparam int POS_ZERO_RISE_LATEST    = 20;
  localparam int POS_ZERO_RISE_EARLIEST  = 16;
  localparam int POS_ONE_RISE_LATEST     = 12;
  localparam int POS_ONE_RISE_EARLIEST   = 8;
  localparam int POS_WAVE_CHECK_ENABLE   = 0;
  localparam int POS_RX_ENABLE           = 0;

  // Status / mask bit positions
  localparam int POS_EV_START_OK  = 0;
  localparam int POS_EV_START_ERR = 1;
  localparam int POS_EV_WAVE_ERR  = 2;

  // Threshold bases in sampling-clock periods
  localparam logic [7:0] BASE_START_PERIOD_MAX    = 8'd154;
  localparam logic [7:0] BASE_START_PERIOD_MIN    = 8'd141;
  localparam logic [7:0] BASE_START_RISE_LATEST   = 8'd128;
  localparam logic [7:0] BASE_START_RISE_EARLIEST = 8'd115;
  localparam logic [7:0] BASE_ZERO_RISE_LATEST    = 8'd56;
  localparam logic [7:0] BASE_ZERO_RISE_EARLIEST  = 8'd43;
  localparam logic [7:0] BASE_ONE_RISE_LATEST     = 8'd26;
  localparam logic [7:0] BASE_ONE_RISE_EARLIEST   = 8'd13;

  // Sampling clock derived from the system clock
  localparam int CLK_HZ    = 250_000_000;
  localparam int SAMPLE_HZ = 32_768;
  localparam int SAMPLE_DIV_CYCLES = CLK_HZ / SAMPLE_HZ;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_START    = 2'b01,
    ST_BIT_LOW  = 2'b10,
    ST_BIT_HIGH = 2'b11
  } rx_state_type;

  typedef struct packed {
    logic wave_err;
    logic start_err;
    logic start_ok;
  } rx_events_type;

  typedef struct packed {
    logic [7:0] start_period_max;
    logic [7:0] start_period_min;
    logic [7:0] start_rise_latest;
    logic [7:0] start_rise_earliest;
    logic [7:0] zero_rise_latest;
    logic [7:0] zero_rise_earliest;
    logic [7:0] one_rise_latest;
    logic [7:0] one_rise_earliest;
  } rx_limits_type;

endpackage

// ==== testbench/cec_line_model.sv ====
// Other devices on the shared line: open-drain with pull-up, so a released
// line reads high. Assumes times are given in sample ticks of DIV clocks.
`timescale 1ns/1ps
module cec_line_model #(
  parameter int DIV = 4
) (
  input  wire logic clk,
  output logic      line
);
  initial line = 1'b1;

  task automatic hold(input logic lvl, input int ticks);
    line <= lvl;
    repeat (ticks * DIV) @(posedge clk);
  endtask

  // Start bit, one data bit, then idle past any start maximum to end the frame
  task automatic send(input int rise, input int period, input int low, input int gap);
    hold(1'b0, rise);
    hold(1'b1, period - rise);
    hold(1'b0, low);
    hold(1'b1, gap);
  endtask
endmodule

// ==== testbench/cec_rx_timing_checker_properties.sv ====
// Assertions on the register bus and interrupt of the timing checker.
// Assumes one clock, MCLK, and asynchronous active-low NRST.
`timescale 1ns/1ps
module cec_rx_timing_props
  import cec_rx_timing_pkg::*;
#(
  parameter int SAMPLE_DIV = SAMPLE_DIV_CYCLES
) (
  input wire logic        MCLK,
  input wire logic        NRST,
  input wire logic        CEC_IN,
  input wire logic [7:0]  S_AXI_AWADDR,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0]  S_AXI_WSTRB,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic [7:0]  S_AXI_ARADDR,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic        IRQ
);
  logic [7:0] ar_q;

  default clocking @(posedge MCLK); endclocking
  default disable iff (!NRST);

  // Address of the read under way, to judge the data it returns
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      ar_q <= 8'h00;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      ar_q <= S_AXI_ARADDR;
    end
  end

  ////////////////////////////////////////
  property p_wr_resp;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
  property p_rd_resp;
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
  property p_b_block;
    S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY;
  endproperty
  a_b_block: assert property (p_b_block) else $error("write taken during answer");
  property p_b_once;
    S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID;
  endproperty
  a_b_once: assert property (p_b_once) else $error("write answer repeated");
  property p_r_block;
    S_AXI_RVALID |-> !S_AXI_ARREADY;
  endproperty
  a_r_block: assert property (p_r_block) else $error("read taken during answer");
  property p_r_once;
    S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID;
  endproperty
  a_r_once: assert property (p_r_once) else $error("read answer repeated");
  property p_start_rsvd;
    S_AXI_RVALID && ar_q == OFS_START_TIMING |-> (S_AXI_RDATA & 32'hFFFF_8888) == 32'h0000_0000;
  endproperty
  a_start_rsvd: assert property (p_start_rsvd)
    else $error("start timing spare bits set");
  property p_wave_rsvd;
    S_AXI_RVALID && ar_q == OFS_WAVE_CHECK |-> (S_AXI_RDATA & 32'hFF88_88FE) == 32'h0000_0000;
  endproperty
  a_wave_rsvd: assert property (p_wave_rsvd)
    else $error("waveform spare bits set");
  property p_unmapped;
    S_AXI_RVALID && ar_q > OFS_RX_CONTROL |-> S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == 0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_irq_fall;
    $fell(IRQ) |-> $rose(S_AXI_BVALID);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped unasked");

  c_irq: cover property ($rose(IRQ));
  c_unmapped: cover property (S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR);
  c_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
endmodule

bind cec_rx_timing_checker cec_rx_timing_props #(.SAMPLE_DIV(SAMPLE_DIV)) u_cec_rx_timing_props (
  .MCLK(MCLK), .NRST(NRST), .CEC_IN(CEC_IN), .S_AXI_AWADDR(S_AXI_AWADDR),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
  .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .IRQ(IRQ));

// ==== testbench/tb_cec_rx_timing_checker.sv ====
// Self-checking bench: registers, start-bit windows, waveform errors, IRQ.
// Assumes the line model drives the line and a sample divider of 4.
`timescale 1ns/1ps
module tb_cec_rx_timing_checker
  import cec_rx_timing_pkg::*;
();
  localparam int DIV = 4;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  wire         cec_line;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        arvalid = 1'b0;
  wire         awready, wready, bvalid, arready, rvalid, irq;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  int          failures = 0;
  int          n_checks = 0;

  always #2 mclk = ~mclk;

  cec_rx_timing_checker #(.SAMPLE_DIV(DIV)) u_cec_rx_timing_checker (
    .MCLK(mclk), .NRST(nrst), .CEC_IN(cec_line), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(1'b1),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(1'b1), .IRQ(irq));
  cec_line_model #(.DIV(DIV)) u_cec_line_model (.clk(mclk), .line(cec_line));

  ////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // Each channel is released at the rising edge that takes it
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic b;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      b = bvalid;
      r = bresp;
    end while (!b);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic rv;
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      rv = rvalid;
      d  = rdata;
      r  = rresp;
    end while (!rv);
  endtask

  task automatic rd_exp(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk(what, exp, d);
  endtask

  // Timing is only changed with reception stopped and confirmed stopped
  task automatic cfg(input logic [7:0] a, input logic [31:0] v);
    logic [1:0] r;
    axi_wr(OFS_RX_CONTROL, 32'h0000_0000, r);
    rd_exp(OFS_RX_CONTROL, 32'h0000_0000, "rx enable");
    axi_wr(a, v, r);
    axi_wr(OFS_RX_CONTROL, 32'h0000_0001, r);
  endtask

  ////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 5; i++) begin
      rd_exp(8'(4 * i), 32'h0000_0000, "reset value");
    end
    axi_wr(OFS_START_TIMING, 32'hFFFF_FFFF, r);
    rd_exp(OFS_START_TIMING, 32'h0000_7777, "start timing");
    wstrb <= 4'h1;
    axi_wr(OFS_START_TIMING, 32'h0000_0000, r);
    wstrb <= 4'hF;
    rd_exp(OFS_START_TIMING, 32'h0000_7700, "byte lanes");
    axi_wr(OFS_WAVE_CHECK, 32'hFFFF_FFFF, r);
    rd_exp(OFS_WAVE_CHECK, 32'h0077_7701, "wave check");
    axi_wr(8'h20, 32'h0000_0001, r);
    chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, r});
    axi_rd(8'h20, d, r);
    chk("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("unmapped data", 32'h0000_0000, d);
    axi_wr(OFS_WAVE_CHECK, 32'h0000_0000, r);
  endtask

  // Margins of at least two ticks keep the sampling phase out of the verdict
  task automatic t_start();
    logic [1:0] r;
    int tb_ [9][4] = '{'{0, 121, 147, 1}, '{0, 110, 147, 2}, '{'h7, 110, 147, 1},
      '{0, 132, 147, 2}, '{'h70, 132, 147, 1}, '{0, 121, 158, 2}, '{'h7000, 121, 158, 1},
      '{0, 121, 137, 2}, '{'h700, 121, 137, 1}};
    axi_wr(OFS_IRQ_MASK, 32'h0000_0000, r);
    for (int i = 0; i < 9; i++) begin
      cfg(OFS_START_TIMING, 32'(tb_[i][0]));
      u_cec_line_model.send(tb_[i][1], tb_[i][2], 50, 200);
      rd_exp(OFS_IRQ_STATUS, 32'(tb_[i][3]), "start status");
      chk("masked irq", 32'h0000_0000, {31'h0, irq});
      axi_wr(OFS_IRQ_STATUS, 32'h0000_0007, r);
      rd_exp(OFS_IRQ_STATUS, 32'h0000_0000, "status cleared");
    end
  endtask

  task automatic t_wave();
    logic [1:0] r;
    int tb_ [12][3] = '{'{'h1, 20, 0}, '{'h1, 8, 1}, '{'h701, 8, 0}, '{'h1, 30, 1},
      '{'h7001, 30, 0}, '{'h1, 39, 1}, '{'h70001, 39, 0}, '{'h1, 60, 1},
      '{'h700001, 60, 0}, '{'h0, 35, 0}, '{'h1, 35, 1}, '{'h1, 50, 0}};
    cfg(OFS_START_TIMING, 32'h0000_0000);
    axi_wr(OFS_IRQ_MASK, 32'h0000_0004, r);
    for (int i = 0; i < 12; i++) begin
      cfg(OFS_WAVE_CHECK, 32'(tb_[i][0]));
      u_cec_line_model.send(121, 147, tb_[i][1], 200);
      rd_exp(OFS_IRQ_STATUS, 32'(1 + 4 * tb_[i][2]),
             "wave status");
      chk("wave irq", 32'(tb_[i][2]), {31'h0, irq});
      axi_wr(OFS_IRQ_STATUS, 32'h0000_0007, r);
      chk("irq cleared", 32'h0000_0000, {31'h0, irq});
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_start();
    t_wave();
    end_sim();
  end

  // About 21 frames of some 1600 clocks each, doubled for margin
  initial begin
    #300_000;
    failures++;
    end_sim();
  end
endmodule
